// File: rtl/spm_regs.svh
// Constants for the shared pin priority multiplexer
// Contract
// RULE_01: Highest enabled function owns a shared pin
// RULE_02: After reset every pin is input
// RULE_03: PA0: analog, timer, keyboard, port
// RULE_04: PA1: analog, timer, keyboard, port
// RULE_05: PA2: interrupt, timer clock, keyboard, port
// RULE_06: PA3: reset, keyboard, port
// RULE_07: PA4: osc out, analog, keyboard, port
// RULE_08: PA5: osc in, analog, keyboard, port
// RULE_09: PB0: analog, SPI clock, port
// RULE_10: PB1: analog, SPI MOSI, port
// RULE_11: PB2: analog, SPI MISO, port
// RULE_12: PB3: analog, SPI select, port
// RULE_13: PB4: analog, serial receive, port
// RULE_14: PB5: analog, serial transmit, port
// RULE_15: PB6/PB7: timer channel over port
// RULE_16: Analog selection never removes other functions
// RULE_17: Software keeps analog pins input, others off
// RULE_18: Drive comes only from winning enabled function
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
`define SPM_NUM_PINS     14
`define SPM_PORT_A_PINS  6
`define SPM_PORT_B_PINS  8
`define SPM_PB_BASE      6
`define SPM_SLOTS        4
`define SPM_SEL_W        2
`define SPM_ANALOG_CHANS 10
`define SPM_TIMER_CHANS  4
`define SPM_KBD_INPUTS   6
`define SPM_OE_N_RESET   14'h3FFF
`endif

// File: rtl/spm_pkg.sv
// Types for the shared pin priority multiplexer
`include "spm_regs.svh"
package spm_pkg;
   typedef enum logic [3:0] {
      FN_GPIO, FN_ANALOG, FN_TIMER, FN_KBD, FN_EXT_INT, FN_TIMER_EXT_CLOCK, FN_RESET,
      FN_OSC_OUT, FN_OSC_IN, FN_SPI_CLK, FN_SPI_MOSI, FN_SPI_MISO,
      FN_SPI_SEL, FN_SER_RX, FN_SER_TX
   } spm_fn_e;

   typedef struct packed {
      logic [`SPM_NUM_PINS-1:0]     s1;
      logic [`SPM_NUM_PINS-1:0]     s2;
      logic [`SPM_NUM_PINS-1:0]     s3;
      logic [`SPM_NUM_PINS-1:0]     sync;
      logic [`SPM_NUM_PINS-1:0]     out;
      logic [`SPM_NUM_PINS-1:0]     oe_n;
      logic [`SPM_NUM_PINS-1:0]     conflict;
      logic [`SPM_ANALOG_CHANS-1:0] analog;
      spm_fn_e [`SPM_NUM_PINS-1:0]  owner;
   } spm_state_s;
endpackage

// File: rtl/spm_pin_cell.sv
// Priority resolver for one shared pin
`timescale 1ns/1ns
`default_nettype none
`include "spm_regs.svh"
module spm_pin_cell #(
   parameter int SLOTS = `SPM_SLOTS,
   parameter int SEL_W = `SPM_SEL_W
) (
   input  wire logic [SLOTS-1:0] en,
   input  wire logic [SLOTS-1:0] pass,
   input  wire logic [SLOTS-1:0] drv,
   input  wire logic [SLOTS-1:0] val,
   output logic      [SEL_W-1:0] sel,
   output logic                  drive_oe,
   output logic                  drive_val,
   output logic                  conflict
);
   logic [SLOTS-1:0] claim;
   logic [SEL_W-1:0] dsel;

   // Lowest index is highest priority
   function automatic logic [SEL_W-1:0] first_one(input logic [SLOTS-1:0] v);
      logic [SEL_W-1:0] r;
      r = SEL_W'(SLOTS - 1);
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = SEL_W'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      // RULE_01: highest enabled wins
      sel = first_one(en);
      // RULE_16: analog slots pass through
      claim = en & ~pass;
      dsel = first_one(claim);
      // RULE_18: winner drives only
      drive_oe = (|claim) & drv[dsel];
      drive_val = (|claim) & drv[dsel] & val[dsel];
      conflict = |(en & (en - SLOTS'(1)));
   end
endmodule
`default_nettype wire

// File: rtl/spm_mux.sv
// Shared pin priority multiplexer for ports A and B
`timescale 1ns/1ns
`default_nettype none
`include "spm_regs.svh"
module spm_mux (
   input  wire logic                         clk,
   input  wire logic                         reset_n,
   input  wire logic [`SPM_NUM_PINS-1:0]     pin_in,
   output logic      [`SPM_NUM_PINS-1:0]     pin_out,
   output logic      [`SPM_NUM_PINS-1:0]     pin_oe_n,
   output logic      [`SPM_NUM_PINS-1:0]     pin_sync,
   output logic      [`SPM_NUM_PINS-1:0]     pin_conflict,
   output spm_pkg::spm_fn_e [`SPM_NUM_PINS-1:0] pin_owner,
   output logic      [`SPM_ANALOG_CHANS-1:0] analog_connect,
   input  wire logic [`SPM_NUM_PINS-1:0]     gpio_dir,
   input  wire logic [`SPM_NUM_PINS-1:0]     gpio_data,
   input  wire logic [`SPM_ANALOG_CHANS-1:0] analog_in_en,
   input  wire logic [`SPM_TIMER_CHANS-1:0]  timer_chan_en,
   input  wire logic [`SPM_TIMER_CHANS-1:0]  timer_chan_oe,
   input  wire logic [`SPM_TIMER_CHANS-1:0]  timer_chan_out,
   input  wire logic [`SPM_KBD_INPUTS-1:0]   keyboard_wake_en,
   input  wire logic                         external_int_en,
   input  wire logic                         timer_ext_clock_en,
   input  wire logic                         reset_pin_en,
   input  wire logic                         osc_output_en,
   input  wire logic                         osc_output_val,
   input  wire logic                         osc_input_en,
   input  wire logic                         spi_clock_en,
   input  wire logic                         spi_clock_oe,
   input  wire logic                         spi_clock_out,
   input  wire logic                         spi_mosi_en,
   input  wire logic                         spi_mosi_oe,
   input  wire logic                         spi_mosi_out,
   input  wire logic                         spi_miso_en,
   input  wire logic                         spi_miso_oe,
   input  wire logic                         spi_miso_out,
   input  wire logic                         spi_select_en,
   input  wire logic                         serial_receive_en,
   input  wire logic                         serial_transmit_en,
   input  wire logic                         serial_transmit_out
);
   import spm_pkg::*;

   spm_state_s st;
   spm_state_s next_st;

   logic    [`SPM_NUM_PINS-1:0][`SPM_SLOTS-1:0] en;
   logic    [`SPM_NUM_PINS-1:0][`SPM_SLOTS-1:0] pass;
   logic    [`SPM_NUM_PINS-1:0][`SPM_SLOTS-1:0] drv;
   logic    [`SPM_NUM_PINS-1:0][`SPM_SLOTS-1:0] val;
   spm_fn_e [`SPM_NUM_PINS-1:0][`SPM_SLOTS-1:0] fn;
   logic    [`SPM_NUM_PINS-1:0][`SPM_SEL_W-1:0] sel;
   logic    [`SPM_NUM_PINS-1:0]                 cell_oe;
   logic    [`SPM_NUM_PINS-1:0]                 cell_val;
   logic    [`SPM_NUM_PINS-1:0]                 cell_conflict;

   // Function table, slot 0 highest priority
   always_comb begin
      en = '0;
      pass = '0;
      drv = '0;
      val = '0;
      for (int p = 0; p < `SPM_NUM_PINS; p++) begin
         for (int s = 0; s < `SPM_SLOTS; s++) begin
            fn[p][s] = FN_GPIO;
         end
      end

      // RULE_03: port A bit 0
      en[0][0] = analog_in_en[0];
      pass[0][0] = 1'b1;
      fn[0][0] = FN_ANALOG;
      en[0][1] = timer_chan_en[0];
      drv[0][1] = timer_chan_oe[0];
      val[0][1] = timer_chan_out[0];
      fn[0][1] = FN_TIMER;
      en[0][2] = keyboard_wake_en[0];
      fn[0][2] = FN_KBD;
      en[0][3] = 1'b1;
      drv[0][3] = gpio_dir[0];
      val[0][3] = gpio_data[0];

      // RULE_04: port A bit 1
      en[1][0] = analog_in_en[1];
      pass[1][0] = 1'b1;
      fn[1][0] = FN_ANALOG;
      en[1][1] = timer_chan_en[1];
      drv[1][1] = timer_chan_oe[1];
      val[1][1] = timer_chan_out[1];
      fn[1][1] = FN_TIMER;
      en[1][2] = keyboard_wake_en[1];
      fn[1][2] = FN_KBD;
      en[1][3] = 1'b1;
      drv[1][3] = gpio_dir[1];
      val[1][3] = gpio_data[1];

      // RULE_05: port A bit 2, input only
      en[2][0] = external_int_en;
      fn[2][0] = FN_EXT_INT;
      en[2][1] = timer_ext_clock_en;
      fn[2][1] = FN_TIMER_EXT_CLOCK;
      en[2][2] = keyboard_wake_en[2];
      fn[2][2] = FN_KBD;
      en[2][3] = 1'b1;

      // RULE_06: port A bit 3
      en[3][0] = reset_pin_en;
      fn[3][0] = FN_RESET;
      en[3][1] = keyboard_wake_en[3];
      fn[3][1] = FN_KBD;
      en[3][2] = 1'b1;
      drv[3][2] = gpio_dir[3];
      val[3][2] = gpio_data[3];

      // RULE_07: port A bit 4
      en[4][0] = osc_output_en;
      drv[4][0] = 1'b1;
      val[4][0] = osc_output_val;
      fn[4][0] = FN_OSC_OUT;
      en[4][1] = analog_in_en[2];
      pass[4][1] = 1'b1;
      fn[4][1] = FN_ANALOG;
      en[4][2] = keyboard_wake_en[4];
      fn[4][2] = FN_KBD;
      en[4][3] = 1'b1;
      drv[4][3] = gpio_dir[4];
      val[4][3] = gpio_data[4];

      // RULE_08: port A bit 5
      en[5][0] = osc_input_en;
      fn[5][0] = FN_OSC_IN;
      en[5][1] = analog_in_en[3];
      pass[5][1] = 1'b1;
      fn[5][1] = FN_ANALOG;
      en[5][2] = keyboard_wake_en[5];
      fn[5][2] = FN_KBD;
      en[5][3] = 1'b1;
      drv[5][3] = gpio_dir[5];
      val[5][3] = gpio_data[5];

      // RULE_09: port B bit 0
      en[6][0] = analog_in_en[4];
      pass[6][0] = 1'b1;
      fn[6][0] = FN_ANALOG;
      en[6][1] = spi_clock_en;
      drv[6][1] = spi_clock_oe;
      val[6][1] = spi_clock_out;
      fn[6][1] = FN_SPI_CLK;
      en[6][2] = 1'b1;
      drv[6][2] = gpio_dir[6];
      val[6][2] = gpio_data[6];

      // RULE_10: port B bit 1
      en[7][0] = analog_in_en[5];
      pass[7][0] = 1'b1;
      fn[7][0] = FN_ANALOG;
      en[7][1] = spi_mosi_en;
      drv[7][1] = spi_mosi_oe;
      val[7][1] = spi_mosi_out;
      fn[7][1] = FN_SPI_MOSI;
      en[7][2] = 1'b1;
      drv[7][2] = gpio_dir[7];
      val[7][2] = gpio_data[7];

      // RULE_11: port B bit 2
      en[8][0] = analog_in_en[6];
      pass[8][0] = 1'b1;
      fn[8][0] = FN_ANALOG;
      en[8][1] = spi_miso_en;
      drv[8][1] = spi_miso_oe;
      val[8][1] = spi_miso_out;
      fn[8][1] = FN_SPI_MISO;
      en[8][2] = 1'b1;
      drv[8][2] = gpio_dir[8];
      val[8][2] = gpio_data[8];

      // RULE_12: port B bit 3
      en[9][0] = analog_in_en[7];
      pass[9][0] = 1'b1;
      fn[9][0] = FN_ANALOG;
      en[9][1] = spi_select_en;
      fn[9][1] = FN_SPI_SEL;
      en[9][2] = 1'b1;
      drv[9][2] = gpio_dir[9];
      val[9][2] = gpio_data[9];

      // RULE_13: port B bit 4
      en[10][0] = analog_in_en[8];
      pass[10][0] = 1'b1;
      fn[10][0] = FN_ANALOG;
      en[10][1] = serial_receive_en;
      fn[10][1] = FN_SER_RX;
      en[10][2] = 1'b1;
      drv[10][2] = gpio_dir[10];
      val[10][2] = gpio_data[10];

      // RULE_14: port B bit 5
      en[11][0] = analog_in_en[9];
      pass[11][0] = 1'b1;
      fn[11][0] = FN_ANALOG;
      en[11][1] = serial_transmit_en;
      drv[11][1] = 1'b1;
      val[11][1] = serial_transmit_out;
      fn[11][1] = FN_SER_TX;
      en[11][2] = 1'b1;
      drv[11][2] = gpio_dir[11];
      val[11][2] = gpio_data[11];

      // RULE_15: port B bits 6 and 7
      en[12][0] = timer_chan_en[2];
      drv[12][0] = timer_chan_oe[2];
      val[12][0] = timer_chan_out[2];
      fn[12][0] = FN_TIMER;
      en[12][1] = 1'b1;
      drv[12][1] = gpio_dir[12];
      val[12][1] = gpio_data[12];
      en[13][0] = timer_chan_en[3];
      drv[13][0] = timer_chan_oe[3];
      val[13][0] = timer_chan_out[3];
      fn[13][0] = FN_TIMER;
      en[13][1] = 1'b1;
      drv[13][1] = gpio_dir[13];
      val[13][1] = gpio_data[13];
   end

   // One resolver per pin
   genvar gp;
   generate
      for (gp = 0; gp < `SPM_NUM_PINS; gp++) begin : g_pin
         spm_pin_cell #(
            .SLOTS (`SPM_SLOTS),
            .SEL_W (`SPM_SEL_W)
         ) u_cell (
            .en        (en[gp]),
            .pass      (pass[gp]),
            .drv       (drv[gp]),
            .val       (val[gp]),
            .sel       (sel[gp]),
            .drive_oe  (cell_oe[gp]),
            .drive_val (cell_val[gp]),
            .conflict  (cell_conflict[gp])
         );
      end
   endgenerate

   // Next state
   always_comb begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Input changes once stages two and three agree
      next_st.sync = (st.s2 & st.s3) | (st.sync & (st.s2 ^ st.s3));
      // RULE_18: registered winner drive
      next_st.out = cell_val;
      next_st.oe_n = ~cell_oe;
      next_st.conflict = cell_conflict;
      // RULE_16: analog adds connection only
      next_st.analog = analog_in_en;
      for (int p = 0; p < `SPM_NUM_PINS; p++) begin
         next_st.owner[p] = fn[p][sel[p]];
      end
      // RULE_02: reset leaves all pins input
      if (!reset_n) begin
         next_st.s1 = '0;
         next_st.s2 = '0;
         next_st.s3 = '0;
         next_st.sync = '0;
         next_st.out = '0;
         next_st.oe_n = `SPM_OE_N_RESET;
         next_st.conflict = '0;
         next_st.analog = '0;
         for (int p = 0; p < `SPM_NUM_PINS; p++) begin
            next_st.owner[p] = FN_GPIO;
         end
      end
   end

   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign pin_out = st.out;
   assign pin_oe_n = st.oe_n;
   assign pin_sync = st.sync;
   assign pin_conflict = st.conflict;
   assign pin_owner = st.owner;
   assign analog_connect = st.analog;
endmodule
`default_nettype wire

// File: test/spm_props.sv
// Assertions on the ports of the shared pin multiplexer
`timescale 1ns/1ns
`default_nettype none
`include "spm_regs.svh"
module spm_props (
   input wire logic                 clk,
   input wire logic                 reset_n,
   input wire logic [13:0]          pin_out,
   input wire logic [13:0]          pin_oe_n,
   input wire logic [13:0]          pin_conflict,
   input wire spm_pkg::spm_fn_e [13:0] pin_owner,
   input wire logic [9:0]           analog_connect,
   input wire logic [9:0]           analog_in_en,
   input wire logic [3:0]           timer_chan_en,
   input wire logic [3:0]           timer_chan_oe,
   input wire logic [3:0]           timer_chan_out,
   input wire logic [5:0]           keyboard_wake_en,
   input wire logic                 external_int_en,
   input wire logic                 reset_pin_en,
   input wire logic                 osc_output_en,
   input wire logic                 osc_output_val,
   input wire logic [13:0]          gpio_dir,
   input wire logic [13:0]          gpio_data
);
   import spm_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_reset_vals;
      $rose(reset_n) |-> pin_oe_n == 14'h3FFF && analog_connect == 10'h000 && pin_conflict == 14'h0000;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset outputs wrong");
   property p_conflict;
      keyboard_wake_en[0] [*2] |-> pin_conflict[0];
   endproperty
   a_conflict: assert property (p_conflict) else $error("conflict flag missing");
   property p_pa0_timer;
      timer_chan_en[0] && timer_chan_oe[0] && !analog_in_en[0] |=>
         pin_owner[0] == FN_TIMER && !pin_oe_n[0] && pin_out[0] == $past(timer_chan_out[0]);
   endproperty
   a_pa0_timer: assert property (p_pa0_timer) else $error("timer does not own pin 0");
   property p_pa1_kbd;
      keyboard_wake_en[1] && !timer_chan_en[1] && !analog_in_en[1] |=>
         pin_owner[1] == FN_KBD && pin_oe_n[1];
   endproperty
   a_pa1_kbd: assert property (p_pa1_kbd) else $error("keyboard does not own pin 1");
   property p_pa2_irq;
      external_int_en |=> pin_owner[2] == FN_EXT_INT && pin_oe_n[2];
   endproperty
   a_pa2_irq: assert property (p_pa2_irq) else $error("interrupt does not own pin 2");
   property p_pa3_rst;
      reset_pin_en |=> pin_owner[3] == FN_RESET && pin_oe_n[3];
   endproperty
   a_pa3_rst: assert property (p_pa3_rst) else $error("reset input does not own pin 3");
   property p_pa4_osc;
      osc_output_en |=> pin_owner[4] == FN_OSC_OUT && !pin_oe_n[4] && pin_out[4] == $past(osc_output_val);
   endproperty
   a_pa4_osc: assert property (p_pa4_osc) else $error("oscillator does not drive pin 4");
   property p_analog_keeps;
      analog_in_en[1] && timer_chan_en[1] && timer_chan_oe[1] |=>
         pin_owner[1] == FN_ANALOG && !pin_oe_n[1] && analog_connect[1];
   endproperty
   a_analog_keeps: assert property (p_analog_keeps) else $error("analog blocked drive");
   property p_pb6_timer;
      timer_chan_en[2] |=> pin_owner[12] == FN_TIMER;
   endproperty
   a_pb6_timer: assert property (p_pb6_timer) else $error("timer does not own pin 12");
   property p_gpio_drive;
      gpio_dir[12] && !timer_chan_en[2] |=> !pin_oe_n[12] && pin_out[12] == $past(gpio_data[12]);
   endproperty
   a_gpio_drive: assert property (p_gpio_drive) else $error("port bit not driven");
   c_reset: cover property ($rose(reset_n));
   c_analog: cover property (analog_in_en[1] && timer_chan_en[1] && timer_chan_oe[1]);
   c_osc: cover property (osc_output_en ##1 osc_output_en);
endmodule
bind spm_mux spm_props i_props (.clk, .reset_n, .pin_out, .pin_oe_n, .pin_conflict, .pin_owner,
   .analog_connect, .analog_in_en, .timer_chan_en, .timer_chan_oe, .timer_chan_out,
   .keyboard_wake_en, .external_int_en, .reset_pin_en, .osc_output_en, .osc_output_val,
   .gpio_dir, .gpio_data);
`default_nettype wire

// File: test/spm_pad_model.sv
// Board side of the shared pads
`timescale 1ns/1ns
`default_nettype none
module spm_pad_model (
   input wire logic [13:0] pin_out,
   input wire logic [13:0] pin_oe_n,
   input wire logic [13:0] ext_en,
   input wire logic [13:0] ext_val,
   output logic     [13:0] pin_in
);
   // Released pads sit at the board pull-up unless ext_en drives them to ext_val
   always_comb begin
      for (int i = 0; i < 14; i++) begin
         pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the shared pin multiplexer
`timescale 1ns/1ns
`default_nettype none
`include "spm_regs.svh"
module tb_top;
   import spm_pkg::*;
   typedef struct {logic [13:0] oe_n, out, conf; logic [9:0] ana; spm_fn_e [13:0] own;} spm_exp_s;
   logic clk = 0, reset_n = 0;
   logic [13:0] pin_in, pin_out, pin_oe_n, pin_conflict, gpio_dir = 0, gpio_data = 0, ext_en, ext_val;
   logic [13:0] pin_sync, pin_seen, sy1, sy2, sy3, sy;
   int apin[10] = '{0, 1, 4, 5, 6, 7, 8, 9, 10, 11};
   int asg[10] = '{-1, -1, 3, 5, 6, 9, 12, 15, 16, 17};
   logic [9:0] analog_connect, analog_in_en = 0;
   logic [3:0] timer_chan_en = 0, timer_chan_oe = 0, timer_chan_out = 0;
   logic [5:0] keyboard_wake_en = 0;
   logic [18:0] sg = 0;
   spm_fn_e [13:0] pin_owner;
   spm_exp_s q[$], e, x;
   int fail_count = 0, n_checks = 0, cyc = 0;
   spm_pad_model i_pad (.pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_in);
   spm_mux i_dut (.clk, .reset_n, .pin_in, .pin_out, .pin_oe_n, .pin_sync, .pin_conflict,
      .pin_owner, .analog_connect, .gpio_dir, .gpio_data, .analog_in_en, .timer_chan_en,
      .timer_chan_oe, .timer_chan_out, .keyboard_wake_en, .external_int_en(sg[0]),
      .timer_ext_clock_en(sg[1]), .reset_pin_en(sg[2]), .osc_output_en(sg[3]),
      .osc_output_val(sg[4]), .osc_input_en(sg[5]), .spi_clock_en(sg[6]), .spi_clock_oe(sg[7]),
      .spi_clock_out(sg[8]), .spi_mosi_en(sg[9]), .spi_mosi_oe(sg[10]), .spi_mosi_out(sg[11]),
      .spi_miso_en(sg[12]), .spi_miso_oe(sg[13]), .spi_miso_out(sg[14]), .spi_select_en(sg[15]),
      .serial_receive_en(sg[16]), .serial_transmit_en(sg[17]), .serial_transmit_out(sg[18]));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic put(int p, logic en, spm_fn_e f, logic inp, logic oe, logic v);
      if (en) begin
         e.own[p] = f;
         e.conf[p] = 1'b1;
         if (f != FN_ANALOG) begin
            e.oe_n[p] = inp | !oe;
            e.out[p] = v;
         end
      end
   endtask
   task automatic calc();
      for (int i = 0; i < 14; i++) begin
         e.own[i] = FN_GPIO;
         e.oe_n[i] = !gpio_dir[i] || i == 2;
         e.out[i] = gpio_data[i];
      end
      e.conf = 14'h0000;
      e.ana = analog_in_en;
      for (int i = 0; i < 2; i++) begin
         put(i, keyboard_wake_en[i], FN_KBD, 1, 0, 0);
         put(i, timer_chan_en[i], FN_TIMER, 0, timer_chan_oe[i], timer_chan_out[i]);
         put(i, analog_in_en[i], FN_ANALOG, 0, 0, 0);
      end
      for (int i = 2; i < 6; i++) put(i, keyboard_wake_en[i], FN_KBD, 1, 0, 0);
      put(2, sg[1], FN_TIMER_EXT_CLOCK, 1, 0, 0);
      put(2, sg[0], FN_EXT_INT, 1, 0, 0);
      put(3, sg[2], FN_RESET, 1, 0, 0);
      put(4, analog_in_en[2], FN_ANALOG, 0, 0, 0);
      put(4, sg[3], FN_OSC_OUT, 0, 1, sg[4]);
      put(5, analog_in_en[3], FN_ANALOG, 0, 0, 0);
      put(5, sg[5], FN_OSC_IN, 1, 0, 0);
      for (int i = 0; i < 3; i++) put(6 + i, sg[6 + 3 * i], spm_fn_e'(FN_SPI_CLK + i), 0,
         sg[7 + 3 * i], sg[8 + 3 * i]);
      put(9, sg[15], FN_SPI_SEL, 1, 0, 0);
      put(10, sg[16], FN_SER_RX, 1, 0, 0);
      put(11, sg[17], FN_SER_TX, 0, 1, sg[18]);
      for (int i = 4; i < 10; i++) put(i + 2, analog_in_en[i], FN_ANALOG, 0, 0, 0);
      for (int i = 2; i < 4; i++) put(i + 10, timer_chan_en[i], FN_TIMER, 0, timer_chan_oe[i],
         timer_chan_out[i]);
      if (!reset_n) begin
         e.oe_n = 14'h3FFF;
         e.conf = 14'h0000;
         e.ana = 10'h000;
         for (int i = 0; i < 14; i++) e.own[i] = FN_GPIO;
      end
   endtask
   task automatic run(string name, int n, logic rst, logic sw = 1'b0);
      repeat (n) begin
         @(negedge clk);
         reset_n = !rst;
         gpio_dir = 14'($urandom);
         gpio_data = 14'($urandom);
         analog_in_en = 10'($urandom & $urandom & $urandom);
         timer_chan_en = 4'($urandom & $urandom);
         timer_chan_oe = 4'($urandom);
         timer_chan_out = 4'($urandom);
         keyboard_wake_en = 6'($urandom & $urandom);
         sg = 19'($urandom & $urandom);
         for (int k = 0; k < 10; k++) begin
            if (sw && analog_in_en[k]) begin
               gpio_dir[apin[k]] = 1'b0;
               if (k < 2) timer_chan_en[k] = 1'b0;
               if (k < 4) keyboard_wake_en[apin[k]] = 1'b0;
               if (asg[k] >= 0) sg[asg[k]] = 1'b0;
            end
         end
         ext_en = 14'($urandom);
         ext_val = 14'($urandom);
         calc();
         q.push_back(e);
      end
      $display("test %s done", name);
   endtask
   task automatic chk(string nm, logic [55:0] exp, logic [55:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Pad level as the next edge will take it
   always @(negedge clk) begin
      #2;
      pin_seen = pin_in;
   end
   always @(posedge clk) begin
      #1;
      if (!reset_n) begin
         {sy, sy3, sy2, sy1} = '0;
      end else begin
         for (int i = 0; i < 14; i++) begin
            if (sy2[i] == sy3[i]) sy[i] = sy2[i];
         end
         {sy3, sy2, sy1} = {sy2, sy1, pin_seen};
      end
      if (q.size() > 0) begin
         x = q.pop_front();
         chk("oe_n", x.oe_n, pin_oe_n);
         chk("out", x.out & ~x.oe_n, pin_out & ~x.oe_n);
         chk("owner", x.own, pin_owner);
         chk("conflict", x.conf, pin_conflict);
         chk("analog", x.ana, analog_connect);
         chk("sync", sy, pin_sync);
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      ext_en = 14'h0000;
      ext_val = 14'h0000;
      void'($urandom(11));
      run("reset", 4, 1);
      run("priority", 400, 0);
      run("analog_only", 200, 0, 1);
      run("midrun_reset", 2, 1);
      run("after_reset", 400, 0);
      @(posedge clk);
      #2;
      tally_and_finish();
   end
endmodule
`default_nettype wire
